/* File: pedc_port_err.sv */
/*
 * pedc_port_err: sticky error detect, error-rate count, first-error packet
 * capture, link timeout and port-write multicast mask pruning for one port.
 * Assumes event inputs are one-cycle pulses synchronous to clk.
 */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
module pedc_port_err
    import pedc_pkg::*;
#(
    parameter int          PORTS     = 16,
    parameter logic [3:0]  PORT_ID   = 4'h0,
    parameter int          CNT_W     = 8
)(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata_q,
    // error events
    input  wire pedc_agg_t         agg_ev,
    input  wire pedc_link_t        link_ev,
    input  wire logic              rx_pkt_end,
    input  wire logic [15:0]       rx_pkt_bytes,
    input  wire logic              ack_wait,
    input  wire logic              ack_rcvd,
    // packet info of the last received packet
    input  wire pedc_pkt_t         rx_pkt,
    input  wire logic [7:0]        rx_tt,
    // port-write steering
    input  wire logic              pw_req,
    input  wire logic              pw_dest_mc,
    input  wire logic [PORTS-1:0]  pw_group_mask,
    output logic                   pw_to_mc_q,
    output logic [PORTS-1:0]       pw_mc_mask_q,
    output logic                   pw_unicast_q,
    // status
    output logic                   capture_valid_q,
    output logic                   aggregate_vendor_error_q
);
    // ==========================================================
    // event vector
    logic [31:0] ev_now;
    logic        oversize_ev;
    logic        link_timeout_ev;
    logic        agg_any;
    logic [31:0] detect_q;
    logic [31:0] rate_en_q;
    logic [23:0] link_timeout_control_q;
    logic [23:0] lt_cnt_q;
    logic [CNT_W-1:0] err_cnt_q;
    pedc_pkt_t   cap_q;
    logic [31:0] cap_attr_q;
    logic        rate_hit;
    logic        cap_now;

    assign agg_any = |agg_ev;
    assign oversize_ev = rx_pkt_end
        && (rx_pkt_bytes > 16'(PEDC_MAX_PKT_BYTES));
    assign link_timeout_ev = ack_wait && !ack_rcvd
        && (lt_cnt_q == link_timeout_control_q);

    always_comb
    begin
        ev_now                  = 32'h00000000;
        ev_now[PEDC_B_AGG]      = agg_any;
        ev_now[PEDC_B_CS_CRC]   = link_ev.cs_crc;
        ev_now[PEDC_B_BAD_ACK]  = link_ev.bad_ack;
        ev_now[PEDC_B_NOT_ACC]  = link_ev.not_acc;
        ev_now[PEDC_B_PKT_ACK]  = link_ev.pkt_ackid;
        ev_now[PEDC_B_PKT_CRC]  = link_ev.pkt_crc;
        ev_now[PEDC_B_OVERSIZE] = oversize_ev;
        ev_now[PEDC_B_LR_ACK]   = link_ev.lr_ackid;
        ev_now[PEDC_B_PROTO]    = link_ev.proto;
        ev_now[PEDC_B_DELIN]    = link_ev.delin;
        ev_now[PEDC_B_UNSOL]    = link_ev.unsol;
        ev_now[PEDC_B_LINK_TMO] = link_timeout_ev;
    end

    assign rate_hit = |(ev_now & rate_en_q);
    assign cap_now  = |(ev_now & rate_en_q & PEDC_CAPTURE_MASK)
        && !capture_valid_q;

    // ==========================================================
    // link timeout counter
    always_ff @(posedge clk)
    begin
        if (!rst_n || !ack_wait || ack_rcvd || link_timeout_ev)
            lt_cnt_q <= 24'h000000;
        else
            lt_cnt_q <= lt_cnt_q + 24'h000001;
    end

    // ==========================================================
    // detect flags: sticky, set wins over a software write
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            detect_q <= PEDC_DETECT_RST;
        else if (reg_wr && reg_addr == PEDC_ADDR_DETECT)
            detect_q <= ((reg_wdata & PEDC_DETECT_MASK) | ev_now);
        else
            detect_q <= detect_q | ev_now;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            aggregate_vendor_error_q <= 1'b0;
        else if (reg_wr && reg_addr == PEDC_ADDR_DETECT)
            aggregate_vendor_error_q <= reg_wdata[PEDC_B_AGG] | agg_any;
        else
            aggregate_vendor_error_q <= aggregate_vendor_error_q | agg_any;
    end

    // ==========================================================
    // configuration
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rate_en_q <= PEDC_RATE_EN_RST;
        else if (reg_wr && reg_addr == PEDC_ADDR_RATE_EN)
            rate_en_q <= reg_wdata & PEDC_DETECT_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            link_timeout_control_q <= PEDC_LT_CTL_RST;
        else if (reg_wr && reg_addr == PEDC_ADDR_LT_CTL)
            link_timeout_control_q <= reg_wdata[23:0];
    end

    // ==========================================================
    // error-rate counter, saturating
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            err_cnt_q <= CNT_W'(PEDC_COUNT_RST);
        else if (reg_wr && reg_addr == PEDC_ADDR_COUNT)
            err_cnt_q <= reg_wdata[CNT_W-1:0];
        else if (rate_hit && !(&err_cnt_q))
            err_cnt_q <= err_cnt_q + CNT_W'(1);
    end

    // ==========================================================
    // capture: valid is set on capture, cleared only by written zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            capture_valid_q <= 1'b0;
        else if (cap_now)
            capture_valid_q <= 1'b1;
        else if (reg_wr && reg_addr == PEDC_ADDR_ATTR && !reg_wdata[PEDC_B_VALID])
            capture_valid_q <= 1'b0;
    end

    // max retry simply latches the last received packet held on rx_pkt
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cap_q      <= '0;
            cap_attr_q <= 32'h00000000;
        end
        else if (cap_now)
        begin
            cap_q      <= rx_pkt;
            cap_attr_q <= {ev_now[31:8] & rate_en_q[31:8], rx_tt};
        end
    end

    // ==========================================================
    // port-write steering
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pw_to_mc_q   <= 1'b0;
            pw_unicast_q <= 1'b0;
            pw_mc_mask_q <= '0;
        end
        else
        begin
            pw_to_mc_q   <= pw_req && pw_dest_mc;
            pw_unicast_q <= pw_req && !pw_dest_mc;
            if (pw_req && pw_dest_mc)
            begin
                pw_mc_mask_q          <= pw_group_mask;
                pw_mc_mask_q[PORT_ID] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // register read, one cycle latency
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata_q <= 32'h00000000;
        else if (!reg_rd)
            reg_rdata_q <= 32'h00000000;
        else if (reg_addr == PEDC_ADDR_DETECT)
            reg_rdata_q <= detect_q;
        else if (reg_addr == PEDC_ADDR_RATE_EN)
            reg_rdata_q <= rate_en_q;
        else if (reg_addr == PEDC_ADDR_ATTR)
            reg_rdata_q <= {cap_attr_q[31:1], capture_valid_q};
        else if (reg_addr == PEDC_ADDR_CAP0)
            reg_rdata_q <= cap_q.w0;
        else if (reg_addr == PEDC_ADDR_CAP1)
            reg_rdata_q <= cap_q.w1;
        else if (reg_addr == PEDC_ADDR_CAP2)
            reg_rdata_q <= cap_q.w2;
        else if (reg_addr == PEDC_ADDR_CAP3)
            reg_rdata_q <= cap_q.w3;
        else if (reg_addr == PEDC_ADDR_CAP4)
            reg_rdata_q <= {24'h000000, cap_attr_q[7:0]};
        else if (reg_addr == PEDC_ADDR_COUNT)
            reg_rdata_q <= 32'(err_cnt_q);
        else if (reg_addr == PEDC_ADDR_LT_CTL)
            reg_rdata_q <= {8'h00, link_timeout_control_q};
        else if (reg_addr == PEDC_ADDR_MC_MASK)
            reg_rdata_q <= 32'(pw_mc_mask_q);
        else
            reg_rdata_q <= 32'h00000000;
    end

    // ==========================================================
    // checks
    capture_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        cap_now |=> capture_valid_q && cap_q == $past(rx_pkt))
        else $error("capture did not set valid");
    capture_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        capture_valid_q && !(reg_wr && reg_addr == PEDC_ADDR_ATTR) |=> $stable(cap_q))
        else $error("capture overwritten while valid");
    capture_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == PEDC_ADDR_ATTR && !reg_wdata[0] && !cap_now
        |=> !capture_valid_q)
        else $error("valid not cleared by write");
    agg_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        agg_any |=> aggregate_vendor_error_q && detect_q[PEDC_B_AGG])
        else $error("aggregate flag missing");
    detect_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        detect_q[PEDC_B_DELIN] && !(reg_wr && reg_addr == PEDC_ADDR_DETECT)
        |=> detect_q[PEDC_B_DELIN])
        else $error("detect flag dropped");
    rate_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        rate_hit && !(reg_wr && reg_addr == PEDC_ADDR_COUNT) && err_cnt_q != '1
        |=> err_cnt_q == $past(err_cnt_q) + CNT_W'(1))
        else $error("rate counter did not step");
    no_cap_delin_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.delin && !agg_any && !(|(ev_now & PEDC_CAPTURE_MASK)) && !capture_valid_q
        |=> !capture_valid_q)
        else $error("delineation captured");
    oversize_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        rx_pkt_end && rx_pkt_bytes == 16'd277 |=> detect_q[PEDC_B_OVERSIZE])
        else $error("oversize not flagged");
    pw_prune_a: assert property (@(posedge clk) disable iff (!rst_n)
        pw_req && pw_dest_mc |=> pw_to_mc_q && !pw_mc_mask_q[PORT_ID])
        else $error("originating port left in mask");
    timeout_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_timeout_ev |=> detect_q[PEDC_B_LINK_TMO])
        else $error("link timeout not flagged");
    count_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
        err_cnt_q == '1 && !(reg_wr && reg_addr == PEDC_ADDR_COUNT) |=> err_cnt_q == '1)
        else $error("rate counter wrapped");
    count_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !rate_hit && !(reg_wr && reg_addr == PEDC_ADDR_COUNT) |=> $stable(err_cnt_q))
        else $error("rate counter moved without enabled error");
    count_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == PEDC_ADDR_COUNT |=> err_cnt_q == $past(reg_wdata[CNT_W-1:0]))
        else $error("rate counter write lost");
    valid_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        capture_valid_q && !(reg_wr && reg_addr == PEDC_ADDR_ATTR) |=> capture_valid_q)
        else $error("capture valid dropped");
    valid_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == PEDC_ADDR_ATTR |=> reg_rdata_q[0] == $past(capture_valid_q))
        else $error("capture valid not readable");
    no_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
        !agg_any && !link_ev.cs_crc && !link_ev.not_acc && !link_ev.pkt_ackid
        && !link_ev.pkt_crc && !oversize_ev && !link_ev.proto && !link_ev.unsol
        && !capture_valid_q |=> !capture_valid_q)
        else $error("capture by an event that never captures");
    oversize_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
        oversize_ev && rate_en_q[PEDC_B_OVERSIZE] && !capture_valid_q |=> capture_valid_q)
        else $error("oversize packet not captured");
    sym_crc_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.cs_crc && rate_en_q[PEDC_B_CS_CRC] && !capture_valid_q |=> capture_valid_q)
        else $error("control symbol crc not captured");
    cs_crc_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.cs_crc |=> detect_q[PEDC_B_CS_CRC])
        else $error("control symbol crc not flagged");
    bad_ack_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.bad_ack |=> detect_q[PEDC_B_BAD_ACK])
        else $error("bad ack ackid not flagged");
    not_acc_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.not_acc |=> detect_q[PEDC_B_NOT_ACC])
        else $error("not accepted not flagged");
    pkt_ack_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.pkt_ackid |=> detect_q[PEDC_B_PKT_ACK])
        else $error("packet ackid not flagged");
    pkt_crc_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.pkt_crc |=> detect_q[PEDC_B_PKT_CRC])
        else $error("packet crc not flagged");
    lr_ack_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.lr_ackid |=> detect_q[PEDC_B_LR_ACK])
        else $error("link response ackid not flagged");
    proto_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.proto |=> detect_q[PEDC_B_PROTO])
        else $error("protocol violation not flagged");
    delin_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.delin |=> detect_q[PEDC_B_DELIN])
        else $error("delineation not flagged");
    unsol_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        link_ev.unsol |=> detect_q[PEDC_B_UNSOL])
        else $error("unsolicited ack not flagged");
    capture_attr_a: assert property (@(posedge clk) disable iff (!rst_n)
        cap_now |=> cap_attr_q[7:0] == $past(rx_tt))
        else $error("captured attribute byte wrong");
    pw_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        pw_req && pw_dest_mc |=> (pw_mc_mask_q | (PORTS'(1) << PORT_ID))
        == ($past(pw_group_mask) | (PORTS'(1) << PORT_ID)))
        else $error("group mask not passed on");
    pw_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        pw_req && !pw_dest_mc |=> pw_unicast_q && !pw_to_mc_q)
        else $error("unicast port-write misrouted");
    pw_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pw_req |=> !pw_to_mc_q && !pw_unicast_q)
        else $error("port-write routed without request");
    agg_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        aggregate_vendor_error_q && !(reg_wr && reg_addr == PEDC_ADDR_DETECT)
        |=> aggregate_vendor_error_q)
        else $error("aggregate flag dropped");
    timeout_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        ack_wait && !ack_rcvd && !link_timeout_ev |=> lt_cnt_q == $past(lt_cnt_q) + 24'h000001)
        else $error("link timeout counter did not step");

    // ==========================================================
    // cover points
    capture_c: cover property (@(posedge clk) disable iff (!rst_n) cap_now);
    blocked_c: cover property (@(posedge clk) disable iff (!rst_n)
        capture_valid_q && rate_hit);
    pw_mc_c: cover property (@(posedge clk) disable iff (!rst_n) pw_req && pw_dest_mc);
    timeout_c: cover property (@(posedge clk) disable iff (!rst_n) link_timeout_ev);
    agg_c: cover property (@(posedge clk) disable iff (!rst_n)
        agg_any && rate_en_q[PEDC_B_AGG]);
endmodule : pedc_port_err
`default_nettype wire

/* File: pedc_pkg.sv */
/*
 * pedc_pkg: register map, field layout, event codes and packet-capture carrier
 * for the per-port error detect and capture block.
 * Assumes a 32-bit register port with one-cycle read latency.
 */
package pedc_pkg;
    // ==========================================================
    // register indices (word offsets on the plain port)
    localparam logic [3:0] PEDC_ADDR_DETECT  = 4'h0;
    localparam logic [3:0] PEDC_ADDR_RATE_EN = 4'h1;
    localparam logic [3:0] PEDC_ADDR_ATTR    = 4'h2;
    localparam logic [3:0] PEDC_ADDR_CAP0    = 4'h3;
    localparam logic [3:0] PEDC_ADDR_CAP1    = 4'h4;
    localparam logic [3:0] PEDC_ADDR_CAP2    = 4'h5;
    localparam logic [3:0] PEDC_ADDR_CAP3    = 4'h6;
    localparam logic [3:0] PEDC_ADDR_CAP4    = 4'h7;
    localparam logic [3:0] PEDC_ADDR_COUNT   = 4'h8;
    localparam logic [3:0] PEDC_ADDR_LT_CTL  = 4'h9;
    localparam logic [3:0] PEDC_ADDR_MC_MASK = 4'ha;
    // ==========================================================
    // error-detect bit positions
    localparam int PEDC_B_AGG      = 31;
    localparam int PEDC_B_CS_CRC   = 22;
    localparam int PEDC_B_BAD_ACK  = 21;
    localparam int PEDC_B_NOT_ACC  = 20;
    localparam int PEDC_B_PKT_ACK  = 19;
    localparam int PEDC_B_PKT_CRC  = 18;
    localparam int PEDC_B_OVERSIZE = 17;
    localparam int PEDC_B_LR_ACK   = 5;
    localparam int PEDC_B_PROTO    = 4;
    localparam int PEDC_B_DELIN    = 2;
    localparam int PEDC_B_UNSOL    = 1;
    localparam int PEDC_B_LINK_TMO = 0;
    localparam logic [31:0] PEDC_DETECT_MASK   = 32'h807e0037;
    // events that may capture a packet; the rest never do
    localparam logic [31:0] PEDC_CAPTURE_MASK  = 32'h805e0012;
    localparam logic [31:0] PEDC_DETECT_RST    = 32'h00000000;
    localparam logic [31:0] PEDC_RATE_EN_RST   = 32'h00000000;
    localparam int          PEDC_B_VALID       = 0;
    localparam logic [7:0]  PEDC_COUNT_RST     = 8'h00;
    localparam logic [23:0] PEDC_LT_CTL_RST    = 24'hffffff;
    localparam int          PEDC_MAX_PKT_BYTES = 276;
    // ==========================================================
    // aggregate sources
    typedef struct packed {
        logic rsvd_tt;
        logic max_retry;
        logic unmapped;
        logic lut_parity;
        logic fabric_transfer_timeout;
        logic mc_timeout;
        logic port_err;
        logic illegal_trans;
        logic ttl;
    } pedc_agg_t;
    // link-level error events
    typedef struct packed {
        logic cs_crc;
        logic bad_ack;
        logic not_acc;
        logic pkt_ackid;
        logic pkt_crc;
        logic lr_ackid;
        logic proto;
        logic delin;
        logic unsol;
    } pedc_link_t;
    // captured packet header words
    typedef struct packed {
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] w2;
        logic [31:0] w3;
    } pedc_pkt_t;
endpackage : pedc_pkg

/* File: pedc_link_partner.sv */
/*
 * pedc_link_partner: link-side event source for the error block.
 * Assumes its tasks are called by the bench, one event at a time.
 */
`timescale 1ns/100ps
`default_nettype none
module pedc_link_partner
    import pedc_pkg::*;
(
    // clock
    input  wire logic        clk,
    // events toward the port
    output var pedc_agg_t    agg_ev,
    output var pedc_link_t   link_ev,
    output logic             rx_pkt_end,
    output logic [15:0]      rx_pkt_bytes,
    output logic             ack_wait,
    output logic             ack_rcvd,
    output var pedc_pkt_t    rx_pkt,
    output logic [7:0]       rx_tt
);
    initial
    begin
        {agg_ev, link_ev, rx_pkt_end, rx_pkt_bytes} = '0;
        {ack_wait, ack_rcvd, rx_pkt, rx_tt} = '0;
    end
    // ==========================================================
    // one-cycle event: 0 link, 1 aggregate source, 2 packet end of length i
    task automatic ev(input int k, input int i, input pedc_pkt_t p);
        @(posedge clk);
        rx_pkt <= p;
        rx_tt <= p.w3[7:0];
        if (k == 0)
            link_ev <= pedc_link_t'(9'h1 << i);
        else if (k == 1)
            agg_ev <= pedc_agg_t'(9'h1 << i);
        else
        begin
            rx_pkt_end <= 1'b1;
            rx_pkt_bytes <= 16'(i);
        end
        @(posedge clk);
        link_ev <= '0;
        agg_ev <= '0;
        rx_pkt_end <= 1'b0;
    endtask : ev
    // ==========================================================
    // outstanding acknowledge, answered after n cycles or never
    task automatic ack_window(input int n, input logic ans);
        @(posedge clk);
        ack_wait <= 1'b1;
        repeat (n) @(posedge clk);
        ack_rcvd <= ans;
        @(posedge clk);
        ack_wait <= 1'b0;
        ack_rcvd <= 1'b0;
    endtask : ack_window
endmodule : pedc_link_partner
`default_nettype wire

/* File: tb_top.sv */
/*
 * tb_top: self-checking bench for pedc_port_err.
 * Assumes the link partner model drives every event input.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import pedc_pkg::*;
;
    localparam logic [3:0] PID = 4'h3;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        pw_req = 1'b0;
    logic        pw_dest_mc = 1'b0;
    logic [15:0] pw_group_mask = '0;
    logic [31:0] rdata;
    logic [15:0] pw_mask;
    logic        pw_mc, pw_uni, cap_valid, agg_err, rx_pkt_end, ack_wait, ack_rcvd;
    logic [15:0] rx_pkt_bytes;
    logic [7:0]  rx_tt;
    pedc_agg_t   agg_ev;
    pedc_link_t  link_ev;
    pedc_pkt_t   rx_pkt, pk, first;
    int          failures = 0;
    int          compares = 0;
    int          seed = 32'h760c;
    int          exp_cnt = 0;
    int          bitpos[9] = '{22, 21, 20, 19, 18, 5, 4, 2, 1};
    logic [31:0] rd_q[$];
    logic [31:0] pw_q[$];
    logic        rd_pend = 1'b0;
    logic [15:0] last_mask = '0;
    always #12.5 clk = ~clk;
    pedc_port_err #(.PORTS(16), .PORT_ID(PID), .CNT_W(8)) dut (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(rdata), .agg_ev(agg_ev), .link_ev(link_ev), .rx_pkt_end(rx_pkt_end),
        .rx_pkt_bytes(rx_pkt_bytes), .ack_wait(ack_wait), .ack_rcvd(ack_rcvd),
        .rx_pkt(rx_pkt), .rx_tt(rx_tt), .pw_req(pw_req), .pw_dest_mc(pw_dest_mc),
        .pw_group_mask(pw_group_mask), .pw_to_mc_q(pw_mc), .pw_mc_mask_q(pw_mask),
        .pw_unicast_q(pw_uni), .capture_valid_q(cap_valid),
        .aggregate_vendor_error_q(agg_err));
    pedc_link_partner lp (.clk(clk), .agg_ev(agg_ev), .link_ev(link_ev),
        .rx_pkt_end(rx_pkt_end), .rx_pkt_bytes(rx_pkt_bytes), .ack_wait(ack_wait),
        .ack_rcvd(ack_rcvd), .rx_pkt(rx_pkt), .rx_tt(rx_tt));
    // ==========================================================
    // compare, bus and verdict tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic chk_valid(input logic e);
        @(posedge clk);
        #1;
        chk({31'h0, cap_valid}, {31'h0, e});
    endtask : chk_valid
    task automatic rnd_pkt;
        pk = {$random(seed), $random(seed), $random(seed), $random(seed)};
    endtask : rnd_pkt
    task automatic cap_rd(input pedc_pkt_t p);
        rd(PEDC_ADDR_CAP0, p.w0);
        rd(PEDC_ADDR_CAP1, p.w1);
        rd(PEDC_ADDR_CAP2, p.w2);
        rd(PEDC_ADDR_CAP3, p.w3);
    endtask : cap_rd
    task automatic pw(input logic mc);
        logic [15:0] m;
        m = 16'($random(seed));
        m[PID] = 1'b1;
        if (mc)
            last_mask = m & ~(16'h1 << PID);
        pw_q.push_back({14'h0, mc, !mc, last_mask});
        @(posedge clk);
        pw_req <= 1'b1;
        pw_dest_mc <= mc;
        pw_group_mask <= m;
        @(posedge clk);
        pw_req <= 1'b0;
    endtask : pw
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // monitor: read data and port-write results against noted values
    always @(posedge clk)
    begin
        if (rd_pend)
            chk(rdata, rd_q.pop_front());
        if (pw_mc || pw_uni)
            chk({14'h0, pw_mc, pw_uni, pw_mask}, pw_q.pop_front());
        rd_pend <= reg_rd;
    end
    initial
    begin
        repeat (6000) @(posedge clk);
        failures++;
        print_verdict;
    end
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(PEDC_ADDR_DETECT, PEDC_DETECT_RST);
        rd(PEDC_ADDR_RATE_EN, PEDC_RATE_EN_RST);
        rd(PEDC_ADDR_LT_CTL, 32'h00ffffff);
        rd(4'hf, 32'h0);
        for (int j = 0; j < 9; j++)
        begin
            rnd_pkt;
            lp.ev(0, 8 - j, pk);
            rd(PEDC_ADDR_DETECT, 32'h1 << bitpos[j]);
            rd(PEDC_ADDR_DETECT, 32'h1 << bitpos[j]);
            wr(PEDC_ADDR_DETECT, 32'h0);
        end
        for (int i = 0; i < 9; i++)
        begin
            lp.ev(1, i, pk);
            rd(PEDC_ADDR_DETECT, 32'h80000000);
            chk({31'h0, agg_err}, 32'h1);
            wr(PEDC_ADDR_DETECT, 32'h0);
        end
        chk_valid(1'b0);
        chk({31'h0, agg_err}, 32'h0);
        lp.ev(2, PEDC_MAX_PKT_BYTES, pk);
        rd(PEDC_ADDR_DETECT, 32'h0);
        lp.ev(2, PEDC_MAX_PKT_BYTES + 1, pk);
        rd(PEDC_ADDR_DETECT, 32'h1 << PEDC_B_OVERSIZE);
        wr(PEDC_ADDR_DETECT, 32'h0);
        wr(PEDC_ADDR_LT_CTL, 32'h8);
        lp.ack_window(3, 1'b1);
        rd(PEDC_ADDR_DETECT, 32'h0);
        lp.ack_window(20, 1'b0);
        rd(PEDC_ADDR_DETECT, 32'h1);
        rd(PEDC_ADDR_COUNT, 32'h0);
        wr(PEDC_ADDR_DETECT, 32'h0);
        wr(PEDC_ADDR_RATE_EN, PEDC_DETECT_MASK);
        for (int j = 0; j < 9; j++)
        begin
            wr(PEDC_ADDR_ATTR, 32'h0);
            rnd_pkt;
            lp.ev(0, 8 - j, pk);
            exp_cnt++;
            chk_valid(PEDC_CAPTURE_MASK[bitpos[j]]);
            if (PEDC_CAPTURE_MASK[bitpos[j]])
                rd(PEDC_ADDR_CAP0, pk.w0);
        end
        first = pk;
        rnd_pkt;
        lp.ev(0, 4, pk);
        exp_cnt++;
        cap_rd(first);
        wr(PEDC_ADDR_ATTR, 32'h0);
        chk_valid(1'b0);
        lp.ev(0, 4, pk);
        exp_cnt++;
        cap_rd(pk);
        wr(PEDC_ADDR_ATTR, 32'h0);
        rnd_pkt;
        lp.ev(1, 6, pk);
        exp_cnt++;
        chk_valid(1'b1);
        cap_rd(pk);
        rd(PEDC_ADDR_ATTR, {8'h80, 16'h0, pk.w3[7:1], 1'b1});
        rd(PEDC_ADDR_CAP4, {24'h0, pk.w3[7:0]});
        wr(PEDC_ADDR_ATTR, 32'h0);
        rnd_pkt;
        lp.ev(2, PEDC_MAX_PKT_BYTES + 24, pk);
        exp_cnt++;
        chk_valid(1'b1);
        rd(PEDC_ADDR_CAP1, pk.w1);
        rd(PEDC_ADDR_COUNT, 32'(exp_cnt));
        wr(PEDC_ADDR_COUNT, 32'h000000fe);
        lp.ev(0, 1, pk);
        lp.ev(0, 1, pk);
        rd(PEDC_ADDR_COUNT, 32'h000000ff);
        repeat (4)
        begin
            pw(1'b1);
            pw(1'b0);
        end
        rd(PEDC_ADDR_MC_MASK, {16'h0, last_mask});
        repeat (6) @(posedge clk);
        print_verdict;
    end
endmodule : tb_top
`default_nettype wire
